// ===== inc/tpw_pkg.sv
// package: register map, field layout and types for the 16-bit timer/pwm block
package tpw_pkg;
    // =========================================================
    // sizes
    localparam int unsigned TPW_NCH_DEF = 2;
    localparam int unsigned TPW_PRE_W = 7;
    // =========================================================
    // register byte offsets
    localparam logic [7:0] TPW_OFF_TSC = 8'h00;
    localparam logic [7:0] TPW_OFF_CNTH = 8'h04;
    localparam logic [7:0] TPW_OFF_CNTL = 8'h08;
    localparam logic [7:0] TPW_OFF_MODH = 8'h0C;
    localparam logic [7:0] TPW_OFF_MODL = 8'h10;
    // channel n sits at page (TPW_CH_PAGE0 + n), 16 bytes per page
    localparam logic [3:0] TPW_CH_PAGE0 = 4'h2;
    localparam logic [1:0] TPW_SUB_CSC = 2'h0;
    localparam logic [1:0] TPW_SUB_VH = 2'h1;
    localparam logic [1:0] TPW_SUB_VL = 2'h2;
    localparam logic [1:0] TPW_SUB_NONE = 2'h3;
    // =========================================================
    // field positions
    localparam int unsigned TSC_FLAG = 7;
    localparam int unsigned TSC_IE = 6;
    localparam int unsigned TSC_CENTER_PWM_MODE = 5;
    localparam int unsigned TSC_CLK_LO = 3;
    localparam int unsigned TSC_PS_LO = 0;
    localparam int unsigned CSC_FLAG = 7;
    localparam int unsigned CSC_IE = 6;
    localparam int unsigned CSC_MSB = 5;
    localparam int unsigned CSC_MSA = 4;
    localparam int unsigned CSC_ELSB = 3;
    localparam int unsigned CSC_ELSA = 2;
    // =========================================================
    // values
    localparam logic [15:0] TPW_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TPW_ZERO16 = 16'h0000;
    localparam logic [7:0] TPW_TSC_RST = 8'h00;
    localparam logic [23:0] TPW_RD_PAD = 24'h000000;

    typedef enum logic [1:0] {
        CLK_NONE = 2'b00,
        CLK_BUS = 2'b01,
        CLK_FIXED = 2'b10,
        CLK_EXT = 2'b11
    } tpw_clk_e;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_CAPTURE = 3'b001,
        MODE_COMPARE = 3'b010,
        MODE_EDGE_PWM_MODE = 3'b011,
        MODE_CENTER_PWM_MODE = 3'b100
    } tpw_mode_e;

    typedef struct packed {
        logic flag;
        logic ie;
        logic center_pwm_mode;
        tpw_clk_e clk;
        logic [2:0] ps;
        logic [15:0] cnt;
        logic [15:0] modv;
        logic down;
        logic [TPW_PRE_W-1:0] pre;
    } tpw_timer_s;

    typedef struct packed {
        logic flag;
        logic ie;
        logic msb;
        logic msa;
        logic elsb;
        logic ela;
        logic [15:0] val;
        logic [15:0] wbuf;
        logic [15:0] rbuf;
        logic wr_hi;
        logic wr_lo;
        logic pend;
        logic rd_lat;
        logic rd_hi;
        logic pin;
        logic oe;
    } tpw_chan_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tpw_sync_s;
endpackage

// ===== rtl/tpw_pin_sync.sv
// two-flop pin synchroniser with edge detection
module tpw_pin_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    tpw_pkg::tpw_sync_s s_r;
    tpw_pkg::tpw_sync_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pin_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.s2;
    assign rise = s_r.s2 & ~s_r.s3;
    assign fall = ~s_r.s2 & s_r.s3;
endmodule

// ===== rtl/tpw_timer_pwm.sv
// 16-bit timer with capture, compare, edge and center pwm channels on apb
//
// Functional notes
// - capture edge: 01 rise, 10 fall, 11 both
// - compare action: 01 toggle, 10 clear, 11 set
// - mode 1X gives edge-aligned pwm polarity
// - center pwm: compare-up clears or sets output
// - center select global, counter goes up/down
// - channel value bytes reset to zero
// - capture read latches other byte until read
// - control write resets channel coherency latches
// - capture mode ignores channel value writes
// - halt freezes read latch, reads live value
// - compare/pwm writes buffered, transfer after both
// - clock none: transfer at second byte
// - compare with clock: transfer on counter tick
// - pwm with clock: transfer at modulus-1 step
// - halt writes keep partial sequence intact
// - clock select: none, bus, fixed, external
// - clock none stops, registers unchanged
// - external clock synchronised, slower than bus/4
// - wrap irq level while flag and enable
// - up mode flag on wrap to zero
// - center mode flag at up-to-down reversal at modulus
// - edge/level 00 releases pin from timer
// - capture or match sets flag, irq option
// - capture latches counter into channel value
// - counter up and wrap, or up/down
module tpw_timer_pwm #(
    parameter int unsigned NCH = tpw_pkg::TPW_NCH_DEF
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_halt,
    input wire logic fixed_clk_tick,
    input wire logic ext_clk_pin,
    input wire logic [NCH-1:0] chan_pin_in,
    output logic [NCH-1:0] chan_pin_out,
    output logic [NCH-1:0] chan_pin_oe,
    output logic wrap_irq,
    output logic [NCH-1:0] chan_irq
);
    typedef struct packed {
        tpw_pkg::tpw_timer_s tm;
        tpw_pkg::tpw_chan_s [NCH-1:0] ch;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic wrap_irq;
        logic [NCH-1:0] chan_irq;
    } tpw_state_s;

    localparam int unsigned TPW_PRE_W_L = tpw_pkg::TPW_PRE_W;

    tpw_state_s s_r;
    tpw_state_s s_nxt;

    logic ext_rise;
    logic [NCH-1:0] pin_rise;
    logic [NCH-1:0] pin_fall;
    logic setup, wr, rd, ch_area, src_tick, cnt_tick, wrap_evt, step_up, pwm_load;
    logic [3:0] ch_idx;
    logic [15:0] term, cnt_step;
    logic [TPW_PRE_W_L-1:0] pre_top;
    tpw_pkg::tpw_mode_e [NCH-1:0] mode;
    logic [NCH-1:0] match, cap_evt, xfer, hit_csc, hit_vh, hit_vl;

    // =========================================================
    // pin synchronisers
    tpw_pin_sync u_ext_sync (
        .clock(clock),
        .rstn(rstn),
        .pin_in(ext_clk_pin),
        .level(),
        .rise(ext_rise),
        .fall()
    );

    for (genvar g = 0; g < NCH; g++) begin : g_sync
        tpw_pin_sync u_sync (
            .clock(clock),
            .rstn(rstn),
            .pin_in(chan_pin_in[g]),
            .level(),
            .rise(pin_rise[g]),
            .fall(pin_fall[g])
        );
    end

    function automatic tpw_pkg::tpw_mode_e mode_of(input logic center_pwm_mode, input tpw_pkg::tpw_chan_s c);
        if (!c.elsb && !c.ela) begin
            return tpw_pkg::MODE_OFF;
        end else if (center_pwm_mode) begin
            return tpw_pkg::MODE_CENTER_PWM_MODE;
        end else if (c.msb) begin
            return tpw_pkg::MODE_EDGE_PWM_MODE;
        end else if (c.msa) begin
            return tpw_pkg::MODE_COMPARE;
        end
        return tpw_pkg::MODE_CAPTURE;
    endfunction

    // =========================================================
    // next state
    always_comb begin
        logic [7:0] rd_byte;
        logic [15:0] wnew;
        logic ok;
        s_nxt = s_r;
        rd_byte = 8'h00;
        wnew = tpw_pkg::TPW_ZERO16;
        setup = psel & ~penable;
        wr = setup & pwrite;
        rd = setup & ~pwrite;
        ch_idx = 4'(paddr[7:4] - tpw_pkg::TPW_CH_PAGE0);
        ch_area = (paddr[7:4] >= tpw_pkg::TPW_CH_PAGE0) && (32'(ch_idx) < NCH)
            && (paddr[3:2] != tpw_pkg::TPW_SUB_NONE);
        ok = ch_area;
        // counter and prescaler
        unique case (s_r.tm.clk)
            tpw_pkg::CLK_NONE: src_tick = 1'b0;
            tpw_pkg::CLK_BUS: src_tick = 1'b1;
            tpw_pkg::CLK_FIXED: src_tick = fixed_clk_tick;
            tpw_pkg::CLK_EXT: src_tick = ext_rise;
        endcase
        pre_top = TPW_PRE_W_L'((8'h01 << s_r.tm.ps) - 8'h01);
        cnt_tick = src_tick & ~debug_halt & (s_r.tm.pre == pre_top);
        if (src_tick && !debug_halt) begin
            s_nxt.tm.pre = cnt_tick ? '0 : TPW_PRE_W_L'(s_r.tm.pre + 1'b1);
        end
        term = (s_r.tm.modv == tpw_pkg::TPW_ZERO16) ? tpw_pkg::TPW_CNT_MAX : s_r.tm.modv;
        pwm_load = cnt_tick && (s_r.tm.cnt == 16'(term - 16'h0001));
        wrap_evt = 1'b0;
        step_up = 1'b1;
        if (!s_r.tm.center_pwm_mode) begin
            wrap_evt = (s_r.tm.cnt == term);
            cnt_step = wrap_evt ? tpw_pkg::TPW_ZERO16 : 16'(s_r.tm.cnt + 16'h0001);
        end else if (!s_r.tm.down) begin
            wrap_evt = (s_r.tm.cnt == term);
            step_up = !wrap_evt;
            cnt_step = wrap_evt ? 16'(s_r.tm.cnt - 16'h0001) : 16'(s_r.tm.cnt + 16'h0001);
        end else begin
            step_up = (s_r.tm.cnt == tpw_pkg::TPW_ZERO16);
            cnt_step = step_up ? 16'(s_r.tm.cnt + 16'h0001) : 16'(s_r.tm.cnt - 16'h0001);
        end
        wrap_evt = wrap_evt & cnt_tick;
        if (cnt_tick) begin
            s_nxt.tm.cnt = cnt_step;
            s_nxt.tm.down = s_r.tm.center_pwm_mode & ~step_up;
        end
        if (wrap_evt) begin
            s_nxt.tm.flag = 1'b1;
        end
        // channel hardware events
        for (int i = 0; i < NCH; i++) begin
            mode[i] = mode_of(s_r.tm.center_pwm_mode, s_r.ch[i]);
            hit_csc[i] = ch_area && (ch_idx == 4'(i)) && (paddr[3:2] == tpw_pkg::TPW_SUB_CSC);
            hit_vh[i] = ch_area && (ch_idx == 4'(i)) && (paddr[3:2] == tpw_pkg::TPW_SUB_VH);
            hit_vl[i] = ch_area && (ch_idx == 4'(i)) && (paddr[3:2] == tpw_pkg::TPW_SUB_VL);
            match[i] = cnt_tick && (cnt_step == s_r.ch[i].val);
            cap_evt[i] = (mode[i] == tpw_pkg::MODE_CAPTURE)
                && ((s_r.ch[i].ela && pin_rise[i]) || (s_r.ch[i].elsb && pin_fall[i]));
            xfer[i] = s_r.ch[i].pend && ((s_r.tm.clk == tpw_pkg::CLK_NONE)
                || ((mode[i] == tpw_pkg::MODE_COMPARE) && cnt_tick)
                || (((mode[i] == tpw_pkg::MODE_EDGE_PWM_MODE) || (mode[i] == tpw_pkg::MODE_CENTER_PWM_MODE))
                    && pwm_load));
            s_nxt.ch[i].oe = (mode[i] != tpw_pkg::MODE_OFF) && (mode[i] != tpw_pkg::MODE_CAPTURE);
            if (xfer[i]) begin
                s_nxt.ch[i].val = s_r.ch[i].wbuf;
                s_nxt.ch[i].pend = 1'b0;
            end
            if (cap_evt[i]) begin
                s_nxt.ch[i].val = s_r.tm.cnt;
                s_nxt.ch[i].flag = 1'b1;
            end
            unique case (mode[i])
                tpw_pkg::MODE_COMPARE: begin
                    if (match[i]) begin
                        s_nxt.ch[i].flag = 1'b1;
                        s_nxt.ch[i].pin = s_r.ch[i].elsb
                            ? s_r.ch[i].ela : ~s_r.ch[i].pin;
                    end
                end
                tpw_pkg::MODE_EDGE_PWM_MODE: begin
                    if (wrap_evt) begin
                        s_nxt.ch[i].pin = ~s_r.ch[i].ela;
                    end
                    if (match[i]) begin
                        s_nxt.ch[i].flag = 1'b1;
                        s_nxt.ch[i].pin = s_r.ch[i].ela;
                    end
                end
                tpw_pkg::MODE_CENTER_PWM_MODE: begin
                    if (match[i]) begin
                        s_nxt.ch[i].flag = 1'b1;
                        s_nxt.ch[i].pin = step_up ? s_r.ch[i].ela : ~s_r.ch[i].ela;
                    end
                    if ((s_r.ch[i].val == tpw_pkg::TPW_ZERO16) || s_r.ch[i].val[15]) begin
                        s_nxt.ch[i].pin = s_r.ch[i].ela;
                    end
                end
                default: begin
                end
            endcase
        end
        // bus: effects commit in the setup cycle, answer one cycle later
        unique case (paddr)
            tpw_pkg::TPW_OFF_TSC: begin
                ok = 1'b1;
                rd_byte = {s_r.tm.flag, s_r.tm.ie, s_r.tm.center_pwm_mode, s_r.tm.clk, s_r.tm.ps};
                if (wr) begin
                    s_nxt.tm.flag = wrap_evt | (s_r.tm.flag & pwdata[tpw_pkg::TSC_FLAG]);
                    s_nxt.tm.ie = pwdata[tpw_pkg::TSC_IE];
                    s_nxt.tm.center_pwm_mode = pwdata[tpw_pkg::TSC_CENTER_PWM_MODE];
                    s_nxt.tm.clk = tpw_pkg::tpw_clk_e'(pwdata[tpw_pkg::TSC_CLK_LO +: 2]);
                    s_nxt.tm.ps = pwdata[tpw_pkg::TSC_PS_LO +: 3];
                end
            end
            tpw_pkg::TPW_OFF_CNTH, tpw_pkg::TPW_OFF_CNTL: begin
                ok = 1'b1;
                rd_byte = (paddr == tpw_pkg::TPW_OFF_CNTH) ? s_r.tm.cnt[15:8] : s_r.tm.cnt[7:0];
                if (wr) begin
                    s_nxt.tm.cnt = tpw_pkg::TPW_ZERO16;
                    s_nxt.tm.pre = '0;
                    s_nxt.tm.down = 1'b0;
                end
            end
            tpw_pkg::TPW_OFF_MODH: begin
                ok = 1'b1;
                rd_byte = s_r.tm.modv[15:8];
                if (wr) begin
                    s_nxt.tm.modv[15:8] = pwdata[7:0];
                end
            end
            tpw_pkg::TPW_OFF_MODL: begin
                ok = 1'b1;
                rd_byte = s_r.tm.modv[7:0];
                if (wr) begin
                    s_nxt.tm.modv[7:0] = pwdata[7:0];
                end
            end
            default: begin
            end
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (hit_csc[i]) begin
                rd_byte = {s_r.ch[i].flag, s_r.ch[i].ie, s_r.ch[i].msb, s_r.ch[i].msa,
                    s_r.ch[i].elsb, s_r.ch[i].ela, 2'b00};
                if (wr) begin
                    s_nxt.ch[i].flag = cap_evt[i] | (match[i] && (mode[i] != tpw_pkg::MODE_OFF)
                        && (mode[i] != tpw_pkg::MODE_CAPTURE))
                        | (s_r.ch[i].flag & pwdata[tpw_pkg::CSC_FLAG]);
                    s_nxt.ch[i].ie = pwdata[tpw_pkg::CSC_IE];
                    s_nxt.ch[i].msb = pwdata[tpw_pkg::CSC_MSB];
                    s_nxt.ch[i].msa = pwdata[tpw_pkg::CSC_MSA];
                    s_nxt.ch[i].elsb = pwdata[tpw_pkg::CSC_ELSB];
                    s_nxt.ch[i].ela = pwdata[tpw_pkg::CSC_ELSA];
                    s_nxt.ch[i].wr_hi = 1'b0;
                    s_nxt.ch[i].wr_lo = 1'b0;
                    s_nxt.ch[i].rd_lat = 1'b0;
                end
            end
            if (hit_vh[i] || hit_vl[i]) begin
                if ((mode[i] == tpw_pkg::MODE_CAPTURE) && !debug_halt && s_r.ch[i].rd_lat) begin
                    rd_byte = hit_vh[i] ? s_r.ch[i].rbuf[15:8] : s_r.ch[i].rbuf[7:0];
                end else begin
                    rd_byte = hit_vh[i] ? s_r.ch[i].val[15:8] : s_r.ch[i].val[7:0];
                end
                if (rd && (mode[i] == tpw_pkg::MODE_CAPTURE) && !debug_halt) begin
                    if (!s_r.ch[i].rd_lat) begin
                        s_nxt.ch[i].rbuf = s_r.ch[i].val;
                        s_nxt.ch[i].rd_lat = 1'b1;
                        s_nxt.ch[i].rd_hi = hit_vh[i];
                    end else if (s_r.ch[i].rd_hi != hit_vh[i]) begin
                        s_nxt.ch[i].rd_lat = 1'b0;
                    end
                end
                if (wr && (mode[i] != tpw_pkg::MODE_CAPTURE)) begin
                    if (debug_halt) begin
                        if (hit_vh[i]) begin
                            s_nxt.ch[i].val[15:8] = pwdata[7:0];
                        end else begin
                            s_nxt.ch[i].val[7:0] = pwdata[7:0];
                        end
                    end else begin
                        wnew = s_r.ch[i].wbuf;
                        if (hit_vh[i]) begin
                            wnew[15:8] = pwdata[7:0];
                        end else begin
                            wnew[7:0] = pwdata[7:0];
                        end
                        s_nxt.ch[i].wbuf = wnew;
                        s_nxt.ch[i].wr_hi = s_r.ch[i].wr_hi | hit_vh[i];
                        s_nxt.ch[i].wr_lo = s_r.ch[i].wr_lo | hit_vl[i];
                        if ((s_r.ch[i].wr_hi | hit_vh[i]) && (s_r.ch[i].wr_lo | hit_vl[i])) begin
                            s_nxt.ch[i].wr_hi = 1'b0;
                            s_nxt.ch[i].wr_lo = 1'b0;
                            if (s_r.tm.clk == tpw_pkg::CLK_NONE) begin
                                s_nxt.ch[i].val = wnew;
                                s_nxt.ch[i].pend = 1'b0;
                            end else begin
                                s_nxt.ch[i].pend = 1'b1;
                            end
                        end
                    end
                end
            end
            s_nxt.chan_irq[i] = s_nxt.ch[i].flag & s_nxt.ch[i].ie;
        end
        s_nxt.wrap_irq = s_nxt.tm.flag & s_nxt.tm.ie;
        s_nxt.pready = setup;
        s_nxt.pslverr = setup & ~ok;
        if (rd) begin
            s_nxt.prdata = {tpw_pkg::TPW_RD_PAD, rd_byte};
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.tm.clk <= tpw_pkg::CLK_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign wrap_irq = s_r.wrap_irq;
    assign chan_irq = s_r.chan_irq;
    for (genvar g = 0; g < NCH; g++) begin : g_out
        assign chan_pin_out[g] = s_r.ch[g].pin;
        assign chan_pin_oe[g] = s_r.ch[g].oe;
    end

    // =========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_CAP_LATCH: assert property (cap_evt[0] |=> s_r.ch[0].val == $past(s_r.tm.cnt))
        else $error("capture did not latch counter");
    AST_CAP_NOWRITE: assert property (wr && (hit_vh[0] || hit_vl[0]) && !cap_evt[0]
        && mode[0] == tpw_pkg::MODE_CAPTURE |=> $stable(s_r.ch[0].val))
        else $error("write changed capture value");
    AST_CLK_STOP: assert property (s_r.tm.clk == tpw_pkg::CLK_NONE
        && !(wr && (paddr == tpw_pkg::TPW_OFF_CNTH || paddr == tpw_pkg::TPW_OFF_CNTL))
        |=> $stable(s_r.tm.cnt))
        else $error("counter moved with no clock");
    AST_WRAP: assert property (cnt_tick && !s_r.tm.center_pwm_mode && s_r.tm.cnt == term
        |=> s_r.tm.flag && s_r.tm.cnt == 16'h0000)
        else $error("wrap did not set flag");
    AST_REVERSE: assert property (cnt_tick && s_r.tm.center_pwm_mode && !s_r.tm.down
        && s_r.tm.cnt == term |=> s_r.tm.flag && s_r.tm.down)
        else $error("center reversal wrong");
    AST_WRAP_IRQ: assert property (##1 wrap_irq == (s_r.tm.flag && s_r.tm.ie))
        else $error("wrap irq not level of flag and enable");
    AST_CSC_CLR: assert property (wr && hit_csc[0]
        |=> !s_r.ch[0].wr_hi && !s_r.ch[0].wr_lo && !s_r.ch[0].rd_lat)
        else $error("control write left latches");
    AST_IMM_XFER: assert property (s_r.tm.clk == tpw_pkg::CLK_NONE |=> !s_r.ch[0].pend)
        else $error("pending value with no clock");
    AST_HALT_RD: assert property (debug_halt && rd && (hit_vh[0] || hit_vl[0])
        |=> $stable(s_r.ch[0].rd_lat) && s_r.prdata[7:0] == (hit_vh[0]
            ? $past(s_r.ch[0].val[15:8]) : $past(s_r.ch[0].val[7:0])))
        else $error("halt read disturbed latch");
    AST_OC_SET: assert property (match[0] && mode[0] == tpw_pkg::MODE_COMPARE
        && s_r.ch[0].elsb && s_r.ch[0].ela |=> chan_pin_out[0])
        else $error("compare set failed");
    AST_PWM_XFER: assert property (xfer[0] && pwm_load && !cap_evt[0]
        |=> s_r.ch[0].val == $past(s_r.ch[0].wbuf))
        else $error("pwm buffer not transferred");
    COV_CAPTURE: cover property (cap_evt[0]);
    COV_EDGE_PWM_MODE_MATCH: cover property (match[0] && mode[0] == tpw_pkg::MODE_EDGE_PWM_MODE);
    COV_CENTER_PWM_MODE_REV: cover property (wrap_evt && s_r.tm.center_pwm_mode);
endmodule

// ===== testbench/tpw_pin_model.sv
// far-side pin model: external clock source and channel pin levels
module tpw_pin_model #(
    parameter int unsigned NCH = 2
) (
    input wire logic clock,
    input wire logic ext_run,
    input wire logic [NCH-1:0] cap_lvl,
    input wire logic [NCH-1:0] chan_pin_out,
    input wire logic [NCH-1:0] chan_pin_oe,
    output logic ext_clk_pin,
    output logic [NCH-1:0] chan_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // external clock, stands still between bursts
    logic [1:0] div_r = 2'h0;
    logic tog_r = 1'b0;
    always @(posedge clock) begin
        if (ext_run) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) begin
                tog_r <= ~tog_r;
            end
        end
    end
    assign ext_clk_pin = tog_r;
    // wire level: the driving party wins
    assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & cap_lvl);
endmodule

// ===== testbench/tb_tpw_timer_pwm.sv
// bench for the timer/pwm block: apb tasks and directed scenarios
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_tpw_timer_pwm;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // signals
    logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, wrap_irq, fixed_clk_tick = 1'b0, ext_run = 1'b0, ext_clk_pin;
    logic [1:0] cap_lvl = 2'h0, chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq;
    logic [7:0] q, a, b;
    logic err, debug_halt = 1'b0;
    int fails = 0, check_count = 0, cyc = 0;
    always #2 clock = ~clock;
    tpw_timer_pwm #(.NCH(2)) u_tpw_timer_pwm (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
        .fixed_clk_tick(fixed_clk_tick),
        .ext_clk_pin(ext_clk_pin), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
        .chan_pin_oe(chan_pin_oe), .wrap_irq(wrap_irq), .chan_irq(chan_irq));
    tpw_pin_model #(.NCH(2)) u_tpw_pin_model (.clock(clock), .ext_run(ext_run),
        .cap_lvl(cap_lvl), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
        .ext_clk_pin(ext_clk_pin), .chan_pin_in(chan_pin_in));
    // =========================================================
    // apb access, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    // =========================================================
    // scenarios
    initial begin
        idle(2);
        rstn <= 1'b1;
        idle(1);
        xfer(0, 8'h00, 8'h00); `CHK("tsc reset", 8'h00, q)
        xfer(0, 8'h24, 8'h00); `CHK("vh reset", 8'h00, q)
        xfer(0, 8'h28, 8'h00); `CHK("vl reset", 8'h00, q)
        xfer(0, 8'h2C, 8'h00); `CHK("unmapped err", 1'b1, err)
        `CHK("oe off", 2'h0, chan_pin_oe)
        xfer(1, 8'h20, 8'h14);
        xfer(1, 8'h24, 8'h00);
        xfer(1, 8'h28, 8'h05);
        xfer(0, 8'h28, 8'h00); `CHK("value at 2nd byte", 8'h05, q)
        `CHK("compare oe", 1'b1, chan_pin_oe[0])
        xfer(1, 8'h00, 8'h08);
        idle(20);
        `CHK("toggle pin", 1'b1, chan_pin_out[0])
        xfer(0, 8'h20, 8'h00); `CHK("match flag", 1'b1, q[7])
        `CHK("no chan irq", 1'b0, chan_irq[0])
        xfer(1, 8'h00, 8'h00);
        xfer(0, 8'h08, 8'h00);
        a = q;
        idle(6);
        xfer(0, 8'h08, 8'h00); `CHK("stopped count", a, q)
        xfer(1, 8'h10, 8'h03);
        xfer(1, 8'h08, 8'h00);
        xfer(1, 8'h00, 8'h48);
        idle(10);
        `CHK("wrap irq", 1'b1, wrap_irq)
        xfer(0, 8'h00, 8'h00); `CHK("wrap flag", 1'b1, q[7])
        xfer(1, 8'h00, 8'h08);
        `CHK("irq masked", 1'b0, wrap_irq)
        xfer(1, 8'h00, 8'h00);
        xfer(1, 8'h10, 8'h00);
        xfer(1, 8'h08, 8'h00);
        xfer(1, 8'h00, 8'h10);
        repeat (3) begin
            fixed_clk_tick <= 1'b1;
            idle(1);
            fixed_clk_tick <= 1'b0;
            idle(2);
        end
        xfer(1, 8'h00, 8'h00);
        xfer(0, 8'h08, 8'h00); `CHK("fixed ticks", 8'h03, q)
        xfer(1, 8'h30, 8'h04);
        cap_lvl <= 2'h2;
        idle(8);
        xfer(0, 8'h30, 8'h00); `CHK("capture flag", 1'b1, q[7])
        xfer(0, 8'h38, 8'h00); `CHK("captured low", 8'h03, q)
        xfer(0, 8'h34, 8'h00); `CHK("captured high", 8'h00, q)
        xfer(1, 8'h38, 8'hAA);
        xfer(0, 8'h38, 8'h00); `CHK("capture write ignored", 8'h03, q)
        xfer(1, 8'h08, 8'h00);
        xfer(1, 8'h00, 8'h18);
        ext_run <= 1'b1;
        idle(80);
        xfer(1, 8'h00, 8'h00);
        ext_run <= 1'b0;
        xfer(0, 8'h08, 8'h00); `CHK("ext counts", 1'b1, q >= 8'h07 && q <= 8'h0C)
        debug_halt <= 1'b1;
        xfer(1, 8'h24, 8'h12);
        xfer(0, 8'h24, 8'h00); `CHK("halt direct write", 8'h12, q)
        xfer(0, 8'h38, 8'h00); `CHK("halt live read", 8'h03, q)
        debug_halt <= 1'b0;
        tally_and_finish();
    end
endmodule
